// >>> pes_defs.svh
// Event codes, unit masks, field positions and widths of the event selector
// Assumes inclusion by pes_pkg.sv and the design modules
`ifndef PES_DEFS_SVH
`define PES_DEFS_SVH

`define PES_CODE_W        8
`define PES_COUNT_W       40

`define PES_EV_DIV        8'h13
`define PES_EV_DIV_BUSY   8'h14
`define PES_EV_DIV_IDLE   8'h18
`define PES_EV_BYPASS     8'h19
`define PES_EV_ADDR_BUS   8'h21
`define PES_EV_READ_DATA  8'h23

`define PES_UM_NONE       8'h00
`define PES_UM_FLOAT      8'h00
`define PES_UM_VECTOR     8'h01
`define PES_UM_LOAD       8'h02

`define PES_CORE_HI       7
`define PES_CORE_LO       6
`define PES_CORE_THIS     2'h1
`define PES_CORE_BOTH     2'h3

`define PES_COUNT_RESET   40'h00_0000_0000
`define PES_COUNT_ONE     40'h00_0000_0001

`endif

// >>> pes_pkg.sv
// Types shared by the event selector and its counters
// Assumes pes_defs.svh is on the include path
`include "pes_defs.svh"

package pes_pkg;
	typedef logic [`PES_CODE_W-1:0]  pes_code_t;
	typedef logic [`PES_COUNT_W-1:0] pes_count_t;
	typedef logic [1:0]              pes_core_t;
endpackage

// >>> pes_counter.sv
// One general counter with synchronous clear and a one-bit increment
// Assumes a single clock and a synchronous active-low reset
`timescale 1ns/10ps
`include "pes_defs.svh"

module pes_counter (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              clear,
	input  wire logic              inc,
	output pes_pkg::pes_count_t    count_r
);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			count_r <= `PES_COUNT_RESET;
		end else if (clear) begin
			// An increment in the clear cycle is kept
			count_r <= inc ? `PES_COUNT_ONE : `PES_COUNT_RESET;
		end else if (inc) begin
			count_r <= count_r + `PES_COUNT_ONE;
		end
	end

endmodule // pes_counter

// >>> pes_top.sv
// Event detection and selection for the two general counters
// Assumes all event inputs are synchronous to clk, one bit per core cycle
`timescale 1ns/10ps
`include "pes_defs.svh"

// What this block does
// - Code 13H mask 00H counts divides, counter one
// - Code 14H mask 00H: divider-busy cycles, counter zero
// - Code 18H counts divider-only-active cycles, counter zero
// - Code 19H mask 00H: float bypass, counter one
// - Code 19H mask 01H: vector bypass, counter one
// - Code 19H mask 02H: load bypass, counter one
// - Code 21H counts address bus busy cycles
// - Code 23H counts read data bus busy cycles
// - Mask selects this core or both cores
module pes_top (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  pes_pkg::pes_code_t     sel0_event,
	input  pes_pkg::pes_code_t     sel0_umask,
	input  wire logic              sel0_enable,
	input  wire logic              sel0_clear,
	input  pes_pkg::pes_code_t     sel1_event,
	input  pes_pkg::pes_code_t     sel1_umask,
	input  wire logic              sel1_enable,
	input  wire logic              sel1_clear,
	input  wire logic              div_issue,
	input  wire logic              div_busy,
	input  wire logic              exec_busy_young,
	input  wire logic              load_busy_young,
	input  wire logic              float_bypass_penalty,
	input  wire logic              vector_bypass_penalty,
	input  wire logic              load_bypass_penalty,
	input  wire logic              addr_bus_this,
	input  wire logic              addr_bus_other,
	input  wire logic              read_data_this,
	input  wire logic              read_data_other,
	output pes_pkg::pes_count_t    general_counter_zero,
	output pes_pkg::pes_count_t    general_counter_one,
	output logic                   sel0_valid_r,
	output logic                   sel1_valid_r
);

	logic inc0_r;
	logic inc1_r;
	logic clear0_r;
	logic clear1_r;
	logic div_only;
	logic second_level_addr_bus_cycles_this;
	logic second_level_addr_bus_cycles_both;
	logic second_level_read_data_cycles_this;
	logic second_level_read_data_cycles_both;
	logic valid0;
	logic valid1;
	logic hit0;
	logic hit1;

	// Divider busy with no younger micro-op active anywhere else
	assign div_only = div_busy & ~exec_busy_young & ~load_busy_young;

	// Shared bus occupancy per qualifier
	assign second_level_addr_bus_cycles_this = addr_bus_this;
	assign second_level_addr_bus_cycles_both =
		addr_bus_this | addr_bus_other;
	assign second_level_read_data_cycles_this = read_data_this;
	assign second_level_read_data_cycles_both =
		read_data_this | read_data_other;

	// Core qualifier taken from the upper unit-mask bits
	function automatic logic bus_hit(
		input pes_pkg::pes_code_t umask,
		input logic               this_core,
		input logic               both_core
	);
		pes_pkg::pes_core_t core;
		core = umask[`PES_CORE_HI:`PES_CORE_LO];
		case (core)
			`PES_CORE_THIS: bus_hit = this_core;
			`PES_CORE_BOTH: bus_hit = both_core;
			default:        bus_hit = 1'b0;
		endcase
	endfunction

	// Encodings legal on counter zero
	function automatic logic legal_zero(
		input pes_pkg::pes_code_t code,
		input pes_pkg::pes_code_t umask
	);
		case (code)
			`PES_EV_DIV_BUSY:  legal_zero = (umask == `PES_UM_NONE);
			`PES_EV_DIV_IDLE:  legal_zero = (umask == `PES_UM_NONE);
			`PES_EV_ADDR_BUS,
			`PES_EV_READ_DATA: legal_zero =
				(umask[`PES_CORE_HI:`PES_CORE_LO] == `PES_CORE_THIS) |
				(umask[`PES_CORE_HI:`PES_CORE_LO] == `PES_CORE_BOTH);
			default:           legal_zero = 1'b0;
		endcase
	endfunction

	// Encodings legal on counter one
	function automatic logic legal_one(
		input pes_pkg::pes_code_t code,
		input pes_pkg::pes_code_t umask
	);
		case (code)
			`PES_EV_DIV:       legal_one = (umask == `PES_UM_NONE);
			`PES_EV_BYPASS:    legal_one = (umask == `PES_UM_FLOAT) |
				(umask == `PES_UM_VECTOR) | (umask == `PES_UM_LOAD);
			`PES_EV_ADDR_BUS,
			`PES_EV_READ_DATA: legal_one =
				(umask[`PES_CORE_HI:`PES_CORE_LO] == `PES_CORE_THIS) |
				(umask[`PES_CORE_HI:`PES_CORE_LO] == `PES_CORE_BOTH);
			default:           legal_one = 1'b0;
		endcase
	endfunction

	assign valid0 = legal_zero(sel0_event, sel0_umask);
	assign valid1 = legal_one(sel1_event, sel1_umask);

	// Event selection for counter zero
	always_comb begin
		hit0 = 1'b0;
		case (sel0_event)
			`PES_EV_DIV_BUSY: begin
				hit0 = div_busy;
			end
			`PES_EV_DIV_IDLE: begin
				hit0 = div_only;
			end
			`PES_EV_ADDR_BUS: begin
				hit0 = bus_hit(sel0_umask,
					second_level_addr_bus_cycles_this,
					second_level_addr_bus_cycles_both);
			end
			`PES_EV_READ_DATA: begin
				hit0 = bus_hit(sel0_umask,
					second_level_read_data_cycles_this,
					second_level_read_data_cycles_both);
			end
			default: begin
				hit0 = 1'b0;
			end
		endcase
	end

	// Event selection for counter one
	always_comb begin
		hit1 = 1'b0;
		case (sel1_event)
			`PES_EV_DIV: begin
				hit1 = div_issue;
			end
			`PES_EV_BYPASS: begin
				case (sel1_umask)
					`PES_UM_FLOAT:  hit1 = float_bypass_penalty;
					`PES_UM_VECTOR: hit1 = vector_bypass_penalty;
					`PES_UM_LOAD:   hit1 = load_bypass_penalty;
					default:        hit1 = 1'b0;
				endcase
			end
			`PES_EV_ADDR_BUS: begin
				hit1 = bus_hit(sel1_umask,
					second_level_addr_bus_cycles_this,
					second_level_addr_bus_cycles_both);
			end
			`PES_EV_READ_DATA: begin
				hit1 = bus_hit(sel1_umask,
					second_level_read_data_cycles_this,
					second_level_read_data_cycles_both);
			end
			default: begin
				hit1 = 1'b0;
			end
		endcase
	end

	// Registered increment for counter zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			inc0_r <= 1'b0;
		end else begin
			inc0_r <= sel0_enable & valid0 & hit0;
		end
	end

	// Registered increment for counter one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			inc1_r <= 1'b0;
		end else begin
			inc1_r <= sel1_enable & valid1 & hit1;
		end
	end

	// Clear requests aligned with the increment stage
	always_ff @(posedge clk) begin
		if (!rstn) begin
			clear0_r <= 1'b0;
			clear1_r <= 1'b0;
		end else begin
			clear0_r <= sel0_clear;
			clear1_r <= sel1_clear;
		end
	end

	// Selection status
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sel0_valid_r <= 1'b0;
			sel1_valid_r <= 1'b0;
		end else begin
			sel0_valid_r <= valid0;
			sel1_valid_r <= valid1;
		end
	end

	pes_counter u_counter_zero (
		.clk     (clk),
		.rstn    (rstn),
		.clear   (clear0_r),
		.inc     (inc0_r),
		.count_r (general_counter_zero)
	);

	pes_counter u_counter_one (
		.clk     (clk),
		.rstn    (rstn),
		.clear   (clear1_r),
		.inc     (inc1_r),
		.count_r (general_counter_one)
	);

endmodule // pes_top

// >>> pes_top_monitor.sv
// Checker for the event selector, watching its ports only
// Assumes a bind onto pes_top and a synchronous active-low reset
`timescale 1ns/10ps

module pes_monitor (
	input wire logic               clk,
	input wire logic               rstn,
	input wire pes_pkg::pes_code_t sel0_event,
	input wire pes_pkg::pes_code_t sel0_umask,
	input wire logic               sel0_enable,
	input wire logic               sel0_clear,
	input wire pes_pkg::pes_code_t sel1_event,
	input wire pes_pkg::pes_code_t sel1_umask,
	input wire logic               sel1_enable,
	input wire logic               sel1_clear,
	input wire logic               div_issue,
	input wire logic               div_busy,
	input wire logic               exec_busy_young,
	input wire logic               load_busy_young,
	input wire logic               float_bypass_penalty,
	input wire logic               vector_bypass_penalty,
	input wire logic               load_bypass_penalty,
	input wire logic               addr_bus_this,
	input wire logic               read_data_other,
	input wire pes_pkg::pes_count_t general_counter_zero,
	input wire pes_pkg::pes_count_t general_counter_one,
	input wire logic               sel0_valid_r,
	input wire logic               sel1_valid_r
);
	wire logic        go0 = sel0_enable && !sel0_clear;
	wire logic        go1 = sel1_enable && !sel1_clear;
	wire logic [15:0] k0  = {sel0_event, sel0_umask};
	wire logic [15:0] k1  = {sel1_event, sel1_umask};

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Counter steps by one two edges after the event
	sequence s_up0;
		##2 general_counter_zero == $past(general_counter_zero) + 40'h1;
	endsequence
	sequence s_up1;
		##2 general_counter_one == $past(general_counter_one) + 40'h1;
	endsequence

	a_div_count_one: assert property (go1 && k1 == 16'h1300 &&
		div_issue |-> s_up1) else $error("divide count missed");
	a_div_busy_zero: assert property (go0 && k0 == 16'h1400 &&
		div_busy |-> s_up0) else $error("divider busy missed");
	a_div_alone_zero: assert property (go0 && k0 == 16'h1800 &&
		div_busy && !exec_busy_young && !load_busy_young |-> s_up0)
		else $error("divider alone missed");
	a_float_pen_one: assert property (go1 && k1 == 16'h1900 &&
		float_bypass_penalty |-> s_up1) else $error("float bypass missed");
	a_vector_pen_one: assert property (go1 && k1 == 16'h1901 &&
		vector_bypass_penalty |-> s_up1) else $error("vector bypass missed");
	a_load_pen_one: assert property (go1 && k1 == 16'h1902 &&
		load_bypass_penalty |-> s_up1) else $error("load bypass missed");
	a_addr_this_zero: assert property (go0 && sel0_event == 8'h21 &&
		sel0_umask[7:6] == 2'h1 && addr_bus_this |-> s_up0)
		else $error("address bus missed");
	a_read_both_one: assert property (go1 && sel1_event == 8'h23 &&
		sel1_umask[7:6] == 2'h3 && read_data_other |-> s_up1)
		else $error("read data both cores missed");
	a_wrong_ctr_zero: assert property (k0 == 16'h1300 |=>
		!sel0_valid_r) else $error("divide accepted on counter zero");
	a_idle_hold_zero: assert property (!sel0_enable && !sel0_clear
		|-> ##2 $stable(general_counter_zero)) else $error("idle count moved");
endmodule // pes_monitor

// >>> pes_top_tb.sv
// Self-checking bench comparing pes_top with a cycle model every cycle
// Assumes the design files and pes_top_monitor.sv are compiled first
`timescale 1ns/10ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end

module pes_top_tb;
	logic               clk = 1'b0, rstn = 1'b0;
	pes_pkg::pes_code_t sel0_event = 8'h00, sel0_umask = 8'h00;
	pes_pkg::pes_code_t sel1_event = 8'h00, sel1_umask = 8'h00;
	logic               sel0_enable = 1'b0, sel0_clear = 1'b0;
	logic               sel1_enable = 1'b0, sel1_clear = 1'b0;
	logic               div_issue = 1'b0, div_busy = 1'b0;
	logic               exec_busy_young = 1'b0, load_busy_young = 1'b0;
	logic               float_bypass_penalty = 1'b0;
	logic               vector_bypass_penalty = 1'b0;
	logic               load_bypass_penalty = 1'b0;
	logic               addr_bus_this = 1'b0, addr_bus_other = 1'b0;
	logic               read_data_this = 1'b0, read_data_other = 1'b0;
	pes_pkg::pes_count_t general_counter_zero, general_counter_one, x0, x1;
	logic               sel0_valid_r, sel1_valid_r, i0, i1, k0, k1, w0, w1;
	logic [7:0]         codes[8] = '{8'h13, 8'h14, 8'h18, 8'h19, 8'h21,
	                                8'h23, 8'h19, 8'h2A};
	logic [7:0]         masks[8] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03,
	                                8'h40, 8'hC0, 8'h80};
	logic [31:0]        r;
	integer             seed = 32'hac3a9025;
	int                 n_errors = 0, check_count = 0;

	pes_top u_dut (.*);

	always #2 clk = ~clk;

	function automatic logic legal(input logic one, input logic [7:0] e, u);
		case (e)
			8'h13: legal = one && u == 8'h00;
			8'h14, 8'h18: legal = !one && u == 8'h00;
			8'h19: legal = one && u <= 8'h02;
			8'h21, 8'h23: legal = u[6];
			default: legal = 1'b0;
		endcase
	endfunction

	function automatic logic src(input logic [7:0] e, u);
		case (e)
			8'h13: src = div_issue;
			8'h14: src = div_busy;
			8'h18: src = div_busy && !exec_busy_young && !load_busy_young;
			8'h19: src = u == 8'h00 ? float_bypass_penalty :
				u == 8'h01 ? vector_bypass_penalty : load_bypass_penalty;
			8'h21: src = addr_bus_this || (u[7] && addr_bus_other);
			8'h23: src = read_data_this || (u[7] && read_data_other);
			default: src = 1'b0;
		endcase
	endfunction

	// Cycle model: event sampled, registered, then added
	always @(posedge clk) begin
		if (!rstn) begin
			{x0, x1, i0, i1, k0, k1, w0, w1} = '0;
		end else begin
			x0 = k0 ? 40'(i0) : x0 + i0;
			x1 = k1 ? 40'(i1) : x1 + i1;
			w0 = legal(1'b0, sel0_event, sel0_umask);
			w1 = legal(1'b1, sel1_event, sel1_umask);
			i0 = sel0_enable && w0 && src(sel0_event, sel0_umask);
			i1 = sel1_enable && w1 && src(sel1_event, sel1_umask);
			k0 = sel0_clear;
			k1 = sel1_clear;
		end
	end

	task automatic final_report;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		for (int n = 0; n < 4000; n++) begin
			@(negedge clk);
			`CHK(general_counter_zero, x0)
			`CHK(general_counter_one, x1)
			`CHK(sel0_valid_r, w0)
			`CHK(sel1_valid_r, w1)
			rstn = (n % 1500 != 1499);
			r = $random(seed);
			{div_issue, div_busy, exec_busy_young, load_busy_young,
				float_bypass_penalty, vector_bypass_penalty,
				load_bypass_penalty, addr_bus_this, addr_bus_other,
				read_data_this, read_data_other} = r[10:0];
			sel0_event = codes[r[13:11]];
			sel1_event = codes[r[16:14]];
			sel0_umask = masks[r[19:17]];
			sel1_umask = masks[r[22:20]];
			sel0_enable = r[23];
			sel1_enable = r[24];
			sel0_clear = &r[28:25];
			sel1_clear = &r[31:28];
		end
		final_report();
	end
endmodule // pes_top_tb

bind pes_top pes_monitor u_mon (.*);
